// ===== rsc_pkg.sv
// Package for the reset source controller: register map, fields, timing.
package rsc_pkg;
  // Register offsets (byte addresses)
  localparam logic [7:0] RSC_OFF_CAUSE = 8'h00;
  localparam logic [7:0] RSC_OFF_BOR_CTRL = 8'h04;
  localparam logic [7:0] RSC_OFF_OSC_CTRL = 8'h08;
  localparam logic [7:0] RSC_OFF_SYS_CTRL = 8'h0c;
  localparam logic [7:0] RSC_OFF_SRST0 = 8'h10;
  localparam logic [7:0] RSC_OFF_SRST1 = 8'h14;
  localparam logic [7:0] RSC_OFF_SRST2 = 8'h18;
  localparam logic [7:0] RSC_OFF_WD_LOAD = 8'h1c;
  localparam logic [7:0] RSC_OFF_WD_CTRL = 8'h20;
  localparam logic [7:0] RSC_OFF_WD_ICR = 8'h24;
  localparam logic [7:0] RSC_OFF_WD_VALUE = 8'h28;
  localparam logic [7:0] RSC_OFF_IDENT0 = 8'h2c;
  localparam logic [7:0] RSC_OFF_IDENT1 = 8'h30;
  localparam logic [7:0] RSC_OFF_CAP0 = 8'h34;
  // Reset-cause bit positions
  localparam int RSC_CAUSE_EXT = 0;
  localparam int RSC_CAUSE_POR = 1;
  localparam int RSC_CAUSE_BOR = 2;
  localparam int RSC_CAUSE_WDT = 3;
  localparam int RSC_CAUSE_SW = 4;
  localparam int RSC_CAUSE_OSC = 5;
  localparam int RSC_CAUSE_W = 6;
  // Control field positions
  localparam int RSC_BOR_RST_EN_BIT = 1;
  localparam int RSC_OSC_CHK_EN_BIT = 0;
  localparam int RSC_SYS_RST_REQ_BIT = 0;
  localparam int RSC_WD_INT_EN_BIT = 0;
  localparam int RSC_WD_RST_EN_BIT = 1;
  // Reset values
  localparam logic [31:0] RSC_WD_LOAD_RST = 32'hffff_ffff;
  localparam logic [31:0] RSC_READ_UNMAPPED = 32'h0000_0000;
  // Identification values are arbitrary
  localparam logic [31:0] RSC_IDENT0_VAL = 32'h0001_0000;
  localparam logic [31:0] RSC_IDENT1_VAL = 32'h0000_0101;
  localparam logic [31:0] RSC_CAP0_VAL = 32'h0003_0007;
  // Internal reset hold after all sources drop
  localparam int RSC_CLK_MHZ = 125;
  localparam int RSC_HOLD_NS = 64;
  localparam int RSC_HOLD_CYC = (RSC_HOLD_NS * RSC_CLK_MHZ + 999) / 1000;
  typedef enum logic [1:0] {RSC_RUN, RSC_HOLD, RSC_FETCH_SP, RSC_FETCH_PC} rsc_seq_t;
endpackage

// ===== rsc_reset_ctrl.sv
// Reset source controller: combines sources, records cause, sequences release.
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// - Six sources each reset the system
// - Set cause bit of causing source
// - Cause bits survive other resets
// - Power-on clears causes, sets power-on bit
// - Power-on resets test port; pin does not
// - Hold reset while power-on detector active
// - After release fetch stack, counter, run
// - Power-on reset only at initial power-up
// - Pin resets core and peripherals only
// - Brown-out reset disabled after reset
// - Brown-out gives interrupt or reset
// - Brown-out reset needs enable bit
// - Brown-out holds reset while present
// - Three peripheral reset registers, set-then-clear
// - Peripheral reset bits match clock gating
// - Peripheral reset hits all its domains
// - Reset request bit resets whole system
// - Watchdog interrupt first, reset second
// - Watchdog reloads 32-bit counter after first
// - Watchdog reset only uncleared and enabled
// - Read-only identification registers
// - Oscillator failure has own cause bit
// - Oscillator check only when enabled
module rsc_reset_ctrl #(
  parameter int PERIPH_W = 32,
  parameter int HOLD_CYC = rsc_pkg::RSC_HOLD_CYC
) (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_srst,
  // Reset sources
  input wire logic i_ext_reset_n,
  input wire logic i_por_active,
  input wire logic i_brownout,
  input wire logic i_osc_fail,
  // Register port
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  // Reset outputs
  output logic o_sys_reset,
  output logic o_tap_reset,
  output logic [3*PERIPH_W-1:0] o_periph_reset,
  output logic o_fetch_sp,
  output logic o_fetch_pc,
  output logic o_core_run,
  // Interrupts towards the core
  output logic o_brownout_irq,
  output logic o_watchdog_irq
);
  import rsc_pkg::*;

  // Elaboration checks: a peripheral word fits one register, the hold counter is
  // sixteen bits wide and the cause register holds one bit per source
  initial begin
    if (PERIPH_W < 1 || PERIPH_W > 32) begin
      $error("rsc_reset_ctrl: PERIPH_W must lie in 1..32");
    end
    if (HOLD_CYC < 1 || HOLD_CYC > 65535) begin
      $error("rsc_reset_ctrl: HOLD_CYC must lie in 1..65535");
    end
    if (RSC_CAUSE_W < 6) begin
      $error("rsc_reset_ctrl: cause register too narrow");
    end
  end

  typedef struct packed {
    // Pin synchroniser
    logic ext_s1;
    logic ext_s2;
    // Causes and configuration
    logic por_seen;
    logic [RSC_CAUSE_W-1:0] cause;
    logic bor_rst_en;
    logic bor_latch;
    logic bor_irq;
    logic osc_chk_en;
    logic sw_req;
    // Peripheral reset registers
    logic [2:0][31:0] srst;
    // Watchdog
    logic [31:0] wd_load;
    logic [31:0] wd_cnt;
    logic wd_int_en;
    logic wd_rst_en;
    logic wd_int;
    logic wd_rst;
    // Release sequencer
    logic [15:0] hold;
    rsc_seq_t seq;
    // Registered outputs
    logic fetch_sp;
    logic fetch_pc;
    logic core_run;
    logic sys_reset;
    logic tap_reset;
    logic [3*PERIPH_W-1:0] periph_reset;
    logic [31:0] rdata;
  } rsc_state_t;

  rsc_state_t st;
  rsc_state_t next_st;

  // Places a single control bit at its field position in a read word
  function automatic logic [31:0] rsc_field(input logic b, input int pos);
    return 32'(b) << pos;
  endfunction

  // Read multiplexer; unmapped and write-only offsets read as zero
  function automatic logic [31:0] rsc_read(input rsc_state_t s, input logic [7:0] a);
    logic [31:0] v;
    v = RSC_READ_UNMAPPED;
    case (a)
      RSC_OFF_CAUSE: v = 32'(s.cause);
      RSC_OFF_BOR_CTRL: v = rsc_field(s.bor_rst_en, RSC_BOR_RST_EN_BIT);
      RSC_OFF_OSC_CTRL: v = rsc_field(s.osc_chk_en, RSC_OSC_CHK_EN_BIT);
      RSC_OFF_SRST0: v = s.srst[0];
      RSC_OFF_SRST1: v = s.srst[1];
      RSC_OFF_SRST2: v = s.srst[2];
      RSC_OFF_WD_LOAD: v = s.wd_load;
      RSC_OFF_WD_CTRL: v = rsc_field(s.wd_int_en, RSC_WD_INT_EN_BIT)
                           | rsc_field(s.wd_rst_en, RSC_WD_RST_EN_BIT);
      RSC_OFF_WD_ICR: v = 32'(s.wd_int);
      RSC_OFF_WD_VALUE: v = s.wd_cnt;
      RSC_OFF_IDENT0: v = RSC_IDENT0_VAL;
      RSC_OFF_IDENT1: v = RSC_IDENT1_VAL;
      RSC_OFF_CAP0: v = RSC_CAP0_VAL;
      default: v = RSC_READ_UNMAPPED;
    endcase
    return v;
  endfunction

  // Next-state logic for the whole block
  always_comb begin
    logic ext_req;
    logic por_req;
    logic bor_req;
    logic osc_req;
    logic wd_req;
    logic sw_sys;
    logic any_req;
    logic wr_here;
    next_st = st;
    ext_req = 1'b0;
    por_req = 1'b0;
    bor_req = 1'b0;
    osc_req = 1'b0;
    wd_req = 1'b0;
    sw_sys = 1'b0;
    any_req = 1'b0;
    wr_here = 1'b0;

    // Two-stage pin synchroniser; only the second stage is used
    next_st.ext_s1 = ~i_ext_reset_n;
    next_st.ext_s2 = st.ext_s1;
    ext_req = st.ext_s2;
    // Detector honoured only until it is first seen released with the system reset low; later pulses are ignored
    por_req = i_por_active & ~st.por_seen;
    if (!i_por_active && !st.sys_reset) begin
      next_st.por_seen = 1'b1;
    end
    // The system reset clears the enable bit, so a latch keeps a brown-out reset
    // going while the supply stays low; without it the request would drop after one
    // cycle and the reset once the hold ran out, with the supply still bad
    bor_req = i_brownout & (st.bor_rst_en | st.bor_latch);
    next_st.bor_latch = bor_req;
    osc_req = i_osc_fail & st.osc_chk_en;
    wd_req = st.wd_rst;
    sw_sys = st.sw_req;
    any_req = ext_req | por_req | bor_req | osc_req | wd_req | sw_sys;

    // Brown-out without reset enable raises the interrupt instead
    if (i_brownout && !st.bor_rst_en && !st.bor_latch) begin
      next_st.bor_irq = 1'b1;
    end

    // Register writes; writes to read-only offsets fall through untouched
    if (i_wr) begin
      case (i_addr)
        // Write-AND: a 0 clears a cause bit, a 1 leaves it
        RSC_OFF_CAUSE: next_st.cause = st.cause & i_wdata[RSC_CAUSE_W-1:0];
        RSC_OFF_BOR_CTRL: begin
          next_st.bor_rst_en = i_wdata[RSC_BOR_RST_EN_BIT];
          next_st.bor_irq = 1'b0;
        end
        RSC_OFF_OSC_CTRL: next_st.osc_chk_en = i_wdata[RSC_OSC_CHK_EN_BIT];
        // Request bit is write-only and reads as 0
        RSC_OFF_SYS_CTRL: next_st.sw_req = i_wdata[RSC_SYS_RST_REQ_BIT];
        RSC_OFF_SRST0: next_st.srst[0] = i_wdata;
        RSC_OFF_SRST1: next_st.srst[1] = i_wdata;
        RSC_OFF_SRST2: next_st.srst[2] = i_wdata;
        RSC_OFF_WD_LOAD: begin
          next_st.wd_load = i_wdata;
          next_st.wd_cnt = i_wdata;
        end
        RSC_OFF_WD_CTRL: begin
          next_st.wd_int_en = st.wd_int_en | i_wdata[RSC_WD_INT_EN_BIT];
          next_st.wd_rst_en = i_wdata[RSC_WD_RST_EN_BIT];
        end
        RSC_OFF_WD_ICR: begin
          wr_here = 1'b1;
          next_st.wd_int = 1'b0;
          next_st.wd_cnt = st.wd_load;
        end
        default: next_st.cause = st.cause;
      endcase
    end

    // Watchdog: first zero interrupts and reloads, second zero resets.
    // A service write in the same cycle as the second zero blocks the reset, but
    // the interrupt stays set, so the next zero resets unless serviced again.
    if (st.wd_int_en && !st.sys_reset) begin
      if (st.wd_cnt == 32'h0000_0000) begin
        next_st.wd_cnt = st.wd_load;
        if (st.wd_int && st.wd_rst_en && !wr_here) begin
          next_st.wd_rst = 1'b1;
        end
        next_st.wd_int = 1'b1;
      end else if (!wr_here) begin
        next_st.wd_cnt = st.wd_cnt - 32'h0000_0001;
      end
    end

    // Cause recording; sticky over other resets, power-on wipes the rest
    if (por_req) begin
      next_st.cause = '0;
      next_st.cause[RSC_CAUSE_POR] = 1'b1;
    end else begin
      if (ext_req) next_st.cause[RSC_CAUSE_EXT] = 1'b1;
      if (bor_req) next_st.cause[RSC_CAUSE_BOR] = 1'b1;
      if (wd_req) next_st.cause[RSC_CAUSE_WDT] = 1'b1;
      if (sw_sys) next_st.cause[RSC_CAUSE_SW] = 1'b1;
      if (osc_req) next_st.cause[RSC_CAUSE_OSC] = 1'b1;
    end

    // Release sequencing; the test port follows power-on only, so a debugger
    // stays attached across pin, brown-out and software resets
    next_st.tap_reset = por_req;
    case (st.seq)
      RSC_RUN: begin
        if (any_req) begin
          next_st.seq = RSC_HOLD;
          next_st.sys_reset = 1'b1;
        end
      end
      RSC_HOLD: begin
        next_st.sys_reset = 1'b1;
        if (any_req) begin
          next_st.hold = HOLD_CYC[15:0];
        end else if (st.hold <= 16'h0001) begin
          next_st.seq = RSC_FETCH_SP;
          next_st.sys_reset = 1'b0;
        end else begin
          next_st.hold = st.hold - 16'h0001;
        end
      end
      RSC_FETCH_SP: next_st.seq = any_req ? RSC_HOLD : RSC_FETCH_PC;
      RSC_FETCH_PC: next_st.seq = any_req ? RSC_HOLD : RSC_RUN;
      default: next_st.seq = RSC_HOLD;
    endcase
    if (any_req) begin
      next_st.sys_reset = 1'b1;
      next_st.hold = HOLD_CYC[15:0];
    end

    // System reset clears everything except sticky causes, power-on memory and the brown-out latch
    if (next_st.sys_reset && any_req) begin
      next_st.sw_req = 1'b0;
      next_st.wd_rst = 1'b0;
      next_st.wd_int = 1'b0;
      next_st.wd_int_en = 1'b0;
      next_st.wd_rst_en = 1'b0;
      next_st.wd_load = RSC_WD_LOAD_RST;
      next_st.wd_cnt = RSC_WD_LOAD_RST;
      next_st.bor_rst_en = 1'b0;
      next_st.bor_irq = 1'b0;
      next_st.osc_chk_en = 1'b0;
      next_st.srst = '0;
    end

    // Sequence flags are registered so that the core sees glitch-free strobes
    next_st.fetch_sp = (next_st.seq == RSC_FETCH_SP);
    next_st.fetch_pc = (next_st.seq == RSC_FETCH_PC);
    next_st.core_run = (next_st.seq == RSC_RUN);

    // Peripheral reset pulses on set-then-clear, driving all its domains
    for (int r = 0; r < 3; r++) begin
      for (int b = 0; b < PERIPH_W; b++) begin
        next_st.periph_reset[r*PERIPH_W+b] = (st.srst[r][b] & ~next_st.srst[r][b])
                                             | next_st.sys_reset;
      end
    end

    // Read data stands for one cycle only and is zero otherwise
    next_st.rdata = i_rd ? rsc_read(st, i_addr) : 32'h0000_0000;
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      // Power-up state: everything held in reset, sequencer counting the hold
      st <= '0;
      st.sys_reset <= 1'b1;
      st.tap_reset <= 1'b1;
      st.seq <= RSC_HOLD;
      st.hold <= HOLD_CYC[15:0];
      st.wd_load <= RSC_WD_LOAD_RST;
      st.wd_cnt <= RSC_WD_LOAD_RST;
      st.periph_reset <= '1;
    end else begin
      st <= next_st;
    end
  end

  // Every output comes straight from the state register
  assign o_rdata = st.rdata;
  assign o_sys_reset = st.sys_reset;
  assign o_tap_reset = st.tap_reset;
  assign o_periph_reset = st.periph_reset;
  assign o_fetch_sp = st.fetch_sp;
  assign o_fetch_pc = st.fetch_pc;
  assign o_core_run = st.core_run;
  assign o_brownout_irq = st.bor_irq;
  assign o_watchdog_irq = st.wd_int;
endmodule // rsc_reset_ctrl
`default_nettype wire

// ===== rsc_pin_model.sv
// Reset pin model: pulled-up pin pulled low by a switch.
`timescale 1ns/10ps
`default_nettype none
module rsc_pin_model #(
  parameter int MIN_LOW = 4
) (
  // Clock
  input wire logic i_clk,
  // Pin
  output logic o_pin_n
);
  initial o_pin_n = 1'b1;
  // Short presses are stretched, so the low time never falls under the minimum
  task automatic press(input int cycles);
    @(posedge i_clk);
    o_pin_n <= 1'b0;
    repeat ((cycles < MIN_LOW) ? MIN_LOW : cycles) @(posedge i_clk);
    o_pin_n <= 1'b1;
  endtask
endmodule // rsc_pin_model
`default_nettype wire

// ===== rsc_reset_ctrl_chk.sv
// Port checker for the reset source controller.
`timescale 1ns/10ps
`default_nettype none
module rsc_reset_ctrl_chk
  import rsc_pkg::*;
#(
  parameter int PERIPH_W = 32
) (
  input wire logic i_clk_sys,
  input wire logic i_srst,
  input wire logic i_ext_reset_n,
  input wire logic i_por_active,
  input wire logic [7:0] i_addr,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [31:0] o_rdata,
  input wire logic o_sys_reset,
  input wire logic o_tap_reset,
  input wire logic [3*PERIPH_W-1:0] o_periph_reset,
  input wire logic o_fetch_sp,
  input wire logic o_fetch_pc,
  input wire logic o_core_run
);
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_srst);
  a_fetch_order: assert property (o_fetch_sp |=> (o_fetch_pc || o_sys_reset) && !o_fetch_sp)
    else $error("stack fetch not followed by counter fetch");
  a_run_after_pc: assert property (o_fetch_pc |=> o_core_run || o_sys_reset)
    else $error("core not running after counter fetch");
  a_run_quiet: assert property (o_core_run |-> !o_sys_reset && !o_fetch_sp)
    else $error("core runs while reset held");
  a_pin_resets: assert property (!i_ext_reset_n [*4] |-> o_sys_reset)
    else $error("pin low without system reset");
  a_pin_no_tap: assert property (!o_tap_reset && !i_por_active |=> !o_tap_reset)
    else $error("test port reset without power-on");
  a_srst_all: assert property (disable iff (1'b0) i_srst |=> o_sys_reset && o_tap_reset)
    else $error("sync reset did not reset all");
  a_ident_ro: assert property ($past(i_rd) && $past(i_addr) == RSC_OFF_IDENT0 |->
    o_rdata == RSC_IDENT0_VAL)
    else $error("identification read wrong");
  a_periph_cause: assert property (o_core_run && $past(o_core_run, 2) && (|o_periph_reset)
    |-> $past(i_wr) || $past(i_wr, 2))
    else $error("peripheral reset without a write");
  a_pulse_one: assert property (o_core_run && (|o_periph_reset) && !i_wr |=> !(|o_periph_reset))
    else $error("peripheral reset longer than one cycle");
endmodule // rsc_reset_ctrl_chk
bind rsc_reset_ctrl rsc_reset_ctrl_chk #(.PERIPH_W(PERIPH_W)) u_chk (.i_clk_sys, .i_srst,
  .i_ext_reset_n, .i_por_active, .i_addr, .i_wr, .i_rd, .o_rdata, .o_sys_reset, .o_tap_reset,
  .o_periph_reset, .o_fetch_sp, .o_fetch_pc, .o_core_run);
`default_nettype wire

// ===== rsc_reset_ctrl_tb_top.sv
// Self-checking testbench for the reset source controller.
`timescale 1ns/10ps
`default_nettype none
module rsc_reset_ctrl_tb_top;
  import rsc_pkg::*;
  logic i_clk_sys = 1'b0, i_srst = 1'b1, i_por_active = 1'b1, i_brownout = 1'b0;
  logic i_osc_fail = 1'b0, i_wr = 1'b0, i_rd = 1'b0, rd_d = 1'b0;
  logic [7:0] i_addr = 8'h00;
  logic [31:0] i_wdata = 32'h0000_0000, o_rdata, exp_cause;
  wire logic i_ext_reset_n;
  logic o_sys_reset, o_tap_reset, o_fetch_sp, o_fetch_pc, o_core_run;
  logic o_brownout_irq, o_watchdog_irq;
  logic [95:0] o_periph_reset;
  logic [31:0] rd_q[$];
  int n_fail = 0, samples_checked = 0, r, i;
  wire logic [3:0] ev = {o_watchdog_irq, o_brownout_irq, o_core_run & ~o_sys_reset, o_sys_reset};
  always #4 i_clk_sys = ~i_clk_sys;
  rsc_reset_ctrl #(.PERIPH_W(32), .HOLD_CYC(2)) dut (.i_clk_sys, .i_srst, .i_ext_reset_n,
    .i_por_active, .i_brownout, .i_osc_fail, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
    .o_sys_reset, .o_tap_reset, .o_periph_reset, .o_fetch_sp, .o_fetch_pc, .o_core_run,
    .o_brownout_irq, .o_watchdog_irq);
  rsc_pin_model #(.MIN_LOW(4)) pin (.i_clk(i_clk_sys), .o_pin_n(i_ext_reset_n));
  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic bad(input string m);
    n_fail++;
    $display("unexpected at %0t: %s", $time, m);
  endtask
  task automatic cmp_rd(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) bad($sformatf("read %h, wanted %h", got, exp));
  endtask
  task automatic cmp_bit(input logic got, input logic exp, input string m);
    samples_checked++;
    if (got !== exp) bad(m);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk_sys);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk_sys);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    rd_q.push_back(exp);
    @(posedge i_clk_sys);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk_sys);
    i_rd <= 1'b0;
    repeat (2) @(posedge i_clk_sys);
  endtask
  // Bounded wait on one event bit: 0 reset, 1 running, 2 brown-out irq, 3 watchdog irq
  task automatic wait_hi(input int k);
    int j;
    for (j = 0; j < 400; j++) begin
      @(posedge i_clk_sys);
      if (ev[k] === 1'b1) break;
    end
    samples_checked++;
    if (j == 400) begin
      bad("wait ran out");
      give_verdict();
    end
  endtask
  always @(posedge i_clk_sys) begin
    rd_d <= i_rd;
    if (rd_d) cmp_rd(o_rdata, rd_q.pop_front());
  end
  initial begin
    void'($urandom(32'h020d9809));
    repeat (20) @(posedge i_clk_sys);
    i_srst <= 1'b0;
    repeat (5) @(posedge i_clk_sys);
    cmp_bit(o_core_run, 1'b0, "ran during power-on");
    cmp_bit(o_tap_reset, 1'b1, "test port not reset by power-on");
    i_por_active <= 1'b0;
    wait_hi(1);
    exp_cause = 32'h1 << RSC_CAUSE_POR;
    rd(RSC_OFF_CAUSE, exp_cause);
    rd(RSC_OFF_IDENT0, RSC_IDENT0_VAL);
    rd(RSC_OFF_CAP0, RSC_CAP0_VAL);
    wr(RSC_OFF_IDENT1, 32'hffff_ffff);
    rd(RSC_OFF_IDENT1, RSC_IDENT1_VAL);
    rd(8'hfc, RSC_READ_UNMAPPED);
    i_por_active <= 1'b1;
    repeat (4) @(posedge i_clk_sys);
    cmp_bit(o_sys_reset, 1'b0, "power-on honoured again");
    i_por_active <= 1'b0;
    r = $urandom_range(95, 0);
    wr(RSC_OFF_SRST0 + 8'(4 * (r / 32)), 32'h1 << (r % 32));
    wr(RSC_OFF_SRST0 + 8'(4 * (r / 32)), 32'h0);
    for (i = 0; i < 4 && o_periph_reset !== (96'h1 << r); i++) @(posedge i_clk_sys);
    cmp_bit(i < 4, 1'b1, "no single peripheral pulse");
    pin.press($urandom_range(12, 2));
    cmp_bit(o_tap_reset, 1'b0, "test port reset by pin");
    wait_hi(1);
    exp_cause |= 32'h1 << RSC_CAUSE_EXT;
    rd(RSC_OFF_CAUSE, exp_cause);
    wr(RSC_OFF_CAUSE, 32'h0);
    exp_cause = 32'h0;
    rd(RSC_OFF_CAUSE, exp_cause);
    i_brownout <= 1'b1;
    wait_hi(2);
    cmp_bit(o_sys_reset, 1'b0, "brown-out reset while disabled");
    i_brownout <= 1'b0;
    wr(RSC_OFF_BOR_CTRL, 32'h1 << RSC_BOR_RST_EN_BIT);
    i_brownout <= 1'b1;
    wait_hi(0);
    repeat (10) @(posedge i_clk_sys);
    cmp_bit(o_sys_reset, 1'b1, "released under brown-out");
    i_brownout <= 1'b0;
    wait_hi(1);
    exp_cause |= 32'h1 << RSC_CAUSE_BOR;
    rd(RSC_OFF_CAUSE, exp_cause);
    wr(RSC_OFF_SYS_CTRL, 32'h1 << RSC_SYS_RST_REQ_BIT);
    wait_hi(0);
    wait_hi(1);
    exp_cause |= 32'h1 << RSC_CAUSE_SW;
    rd(RSC_OFF_CAUSE, exp_cause);
    i_osc_fail <= 1'b1;
    repeat (6) @(posedge i_clk_sys);
    cmp_bit(o_sys_reset, 1'b0, "oscillator check while disabled");
    i_osc_fail <= 1'b0;
    wr(RSC_OFF_OSC_CTRL, 32'h1 << RSC_OSC_CHK_EN_BIT);
    i_osc_fail <= 1'b1;
    wait_hi(0);
    i_osc_fail <= 1'b0;
    wait_hi(1);
    exp_cause |= 32'h1 << RSC_CAUSE_OSC;
    rd(RSC_OFF_CAUSE, exp_cause);
    wr(RSC_OFF_WD_LOAD, 32'($urandom_range(40, 10)));
    wr(RSC_OFF_WD_CTRL, 32'h3);
    wait_hi(3);
    rd(RSC_OFF_WD_ICR, 32'h1);
    cmp_bit(o_sys_reset, 1'b0, "watchdog reset on first time-out");
    wait_hi(0);
    wait_hi(1);
    exp_cause |= 32'h1 << RSC_CAUSE_WDT;
    rd(RSC_OFF_CAUSE, exp_cause);
    give_verdict();
  end
endmodule // rsc_reset_ctrl_tb_top
`default_nettype wire
